// ### tmm_pkg.sv
// Shared constants for the transceiver management monitor.
// Assumes one 50 MHz clock and a byte-wide paged management memory.
package tmm_pkg;
   localparam int LANES = 4;
   localparam int NUM_MON = 14;
   localparam int FLAG_BYTES = 10;
   localparam int MEM_BYTES = 640;
   localparam int NUM_PAGES = 4;
   localparam logic [6:0] DEV_ADDR = 7'h50;
   localparam logic [7:0] FLAG_FIRST = 8'h03;
   localparam int FLAG_MON_BYTE0 = 3;
   localparam logic [7:0] MON_VAL_FIRST = 8'h16;
   localparam logic [7:0] LOW_WR_FIRST = 8'h56;
   localparam logic [7:0] CHAN_DIS_OFS = 8'h56;
   localparam logic [7:0] SQ_DIS_OFS = 8'h57;
   localparam logic [7:0] MASK_FIRST = 8'h64;
   localparam logic [7:0] PAGE_SEL_OFS = 8'h7F;
   localparam logic [7:0] PAGE_COUNT = 8'h04;
   localparam logic [9:0] THR_FLAT = 10'h200;
   localparam logic [10:0] STATUS_IDX = 11'h280;
   localparam logic [7:0] MEM_RESET = 8'h00;
   localparam logic [7:0] THR_HI_RESET = 8'hFF;
endpackage

// ### tmm_link_slave.sv
// Two-wire management link slave: framing, addressing, byte shifting.
// Assumes scl_i and sda_i come straight from pins; sda is open drain.
`timescale 1ns/1ps
module tmm_link_slave (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [7:0] rd_data_i,
   output logic [7:0] ptr_o,
   output logic rd_o,
   output logic wr_o,
   output logic [7:0] wr_data_o
);
   import tmm_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RX_DEV, ST_RX_OFS, ST_RX_DATA, ST_ACK_OUT, ST_TX, ST_ACK_IN
   } tmm_link_state_e;

   logic [2:0] scl_q;
   logic [2:0] sda_q;
   tmm_link_state_e state_q;
   tmm_link_state_e next_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic [7:0] tx_q;
   logic [7:0] ptr_q;
   logic oe_q;
   logic nack_q;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic fall_ok;
   logic load;

   // ----------------------------------------
   // Pin synchronisers and edge detect
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else begin
         scl_q <= {scl_q[1:0], scl_i};
         sda_q <= {sda_q[1:0], sda_i};
      end
   end

   assign scl_rise = scl_q[1] & ~scl_q[2];
   assign scl_fall = ~scl_q[1] & scl_q[2];
   assign start_seen = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
   assign stop_seen = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
   assign fall_ok = scl_fall & ~start_seen & ~stop_seen;
   assign load = fall_ok & (((state_q == ST_ACK_OUT) & (next_q == ST_TX)) |
                 ((state_q == ST_ACK_IN) & ~nack_q));
   assign rd_o = load;
   assign wr_o = fall_ok & (state_q == ST_RX_DATA) & (bit_cnt_q == 4'h8);
   assign wr_data_o = shift_q;
   assign ptr_o = ptr_q;
   assign sda_o = 1'b0;
   assign sda_oe_o = oe_q;

   // ----------------------------------------
   // Byte engine
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_q <= ST_IDLE;
         next_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         oe_q <= 1'b0;
         nack_q <= 1'b0;
      end else if (stop_seen) begin
         state_q <= ST_IDLE;
         oe_q <= 1'b0;
      end else if (start_seen) begin
         state_q <= ST_RX_DEV;
         bit_cnt_q <= 4'h0;
         oe_q <= 1'b0;
      end else if (scl_rise) begin
         unique case (state_q)
            ST_RX_DEV, ST_RX_OFS, ST_RX_DATA: begin
               shift_q <= {shift_q[6:0], sda_q[1]};
               bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            ST_TX: bit_cnt_q <= bit_cnt_q + 4'h1;
            ST_ACK_IN: nack_q <= sda_q[1];
            default: ;
         endcase
      end else if (scl_fall) begin
         if (load) begin
            tx_q <= {rd_data_i[6:0], 1'b0};
            oe_q <= ~rd_data_i[7];
            ptr_q <= ptr_q + 8'h01;
            bit_cnt_q <= 4'h0;
            state_q <= ST_TX;
         end else begin
            unique case (state_q)
               ST_RX_DEV: begin
                  if (bit_cnt_q == 4'h8) begin
                     if (shift_q[7:1] == DEV_ADDR) begin
                        oe_q <= 1'b1;
                        next_q <= shift_q[0] ? ST_TX : ST_RX_OFS;
                        state_q <= ST_ACK_OUT;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
               end
               ST_RX_OFS, ST_RX_DATA: begin
                  if (bit_cnt_q == 4'h8) begin
                     ptr_q <= (state_q == ST_RX_OFS) ? shift_q : ptr_q + 8'h01;
                     oe_q <= 1'b1;
                     next_q <= ST_RX_DATA;
                     state_q <= ST_ACK_OUT;
                  end
               end
               ST_ACK_OUT: begin
                  oe_q <= 1'b0;
                  bit_cnt_q <= 4'h0;
                  state_q <= next_q;
               end
               ST_TX: begin
                  if (bit_cnt_q == 4'h8) begin
                     oe_q <= 1'b0;
                     state_q <= ST_ACK_IN;
                  end else begin
                     oe_q <= ~tx_q[7];
                     tx_q <= {tx_q[6:0], 1'b0};
                  end
               end
               ST_ACK_IN: begin
                  oe_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
               default: ;
            endcase
         end
      end
   end
endmodule

// ### tmm_top.sv
// Management and diagnostics core of a four-lane transceiver.
// Assumes lane status pins are asynchronous and firmware uses AHB-Lite.
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps

module tmm_top (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic interrupt_out_n_o,
   input wire logic [tmm_pkg::LANES-1:0] tx_los_i,
   input wire logic [tmm_pkg::LANES-1:0] tx_fault_i,
   input wire logic [tmm_pkg::LANES-1:0] rx_los_i,
   output logic [tmm_pkg::LANES-1:0] tx_disable_o,
   output logic [tmm_pkg::LANES-1:0] tx_squelch_o,
   output logic [tmm_pkg::LANES-1:0] rx_squelch_o,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o
);
   import tmm_pkg::*;

   logic [7:0] mem_q [MEM_BYTES];
   logic [7:0] flag_q [FLAG_BYTES];
   logic [7:0] flag_set [FLAG_BYTES];
   logic [3:0] mon_nib [NUM_MON];
   logic [FLAG_BYTES-1:0] irq_bits;
   logic [11:0] pin_meta_q;
   logic [11:0] pin_sync_q;
   logic [LANES-1:0] tx_los_s;
   logic [LANES-1:0] tx_fault_s;
   logic [LANES-1:0] rx_los_s;
   logic int_active_q;
   logic [7:0] link_ptr;
   logic [7:0] link_rd_data;
   logic [7:0] link_wr_data;
   logic link_rd;
   logic link_wr;
   logic link_wr_ok;
   logic [7:0] page_sel;
   logic page_ok;
   logic [9:0] link_flat;
   logic ap_valid_q;
   logic ap_write_q;
   logic [10:0] ap_idx_q;
   logic [10:0] ahb_idx;
   logic [31:0] ahb_rd_word;
   logic [31:0] hrdata_q;

   // ----------------------------------------
   // Lane status synchronisers
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         pin_meta_q <= 12'h000;
         pin_sync_q <= 12'h000;
      end else begin
         pin_meta_q <= {tx_los_i, tx_fault_i, rx_los_i};
         pin_sync_q <= pin_meta_q;
      end
   end

   assign tx_los_s = pin_sync_q[11:8];
   assign tx_fault_s = pin_sync_q[7:4];
   assign rx_los_s = pin_sync_q[3:0];

   // ----------------------------------------
   // Two-wire link
   // ----------------------------------------
   // The serial clock is only ever sampled here, never driven.
   tmm_link_slave u_link (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe_o(sda_oe_o),
      .rd_data_i(link_rd_data),
      .ptr_o(link_ptr),
      .rd_o(link_rd),
      .wr_o(link_wr),
      .wr_data_o(link_wr_data)
   );

   // ----------------------------------------
   // Page mapping
   // ----------------------------------------
   assign page_sel = mem_q[PAGE_SEL_OFS];
   assign page_ok = page_sel < PAGE_COUNT;
   assign link_flat = link_ptr[7] ?
                      ({1'b0, page_sel[1:0], 7'h00} + {2'b00, link_ptr}) :
                      {2'b00, link_ptr};
   // Lower control area and pages two and three take writes.
   assign link_wr_ok = link_wr & ((~link_ptr[7] & (link_ptr >= LOW_WR_FIRST)) |
                       (link_ptr[7] & page_ok & page_sel[1]));

   always_comb begin
      link_rd_data = 8'h00;
      if (!link_ptr[7]) begin
         if ((link_ptr >= FLAG_FIRST) && (link_ptr < FLAG_FIRST + 8'(FLAG_BYTES))) begin
            link_rd_data = flag_q[4'(link_ptr - FLAG_FIRST)];
         end else begin
            link_rd_data = mem_q[link_flat];
         end
      end else if (page_ok) begin
         link_rd_data = mem_q[link_flat];
      end
   end

   // ----------------------------------------
   // Management memory
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            // High thresholds start at full scale so nothing trips early.
            if ((i >= int'(THR_FLAT)) && (i < int'(THR_FLAT) + 4 * NUM_MON) &&
                ((i % 2) == 0)) begin
               mem_q[i] <= THR_HI_RESET;
            end else begin
               mem_q[i] <= MEM_RESET;
            end
         end
      end else begin
         if (ap_valid_q && ap_write_q && (ap_idx_q < 11'(MEM_BYTES))) begin
            mem_q[ap_idx_q[9:0]] <= hwdata_i[7:0];
         end
         if (link_wr_ok) begin
            mem_q[link_flat] <= link_wr_data;
         end
      end
   end

   // ----------------------------------------
   // Threshold monitors
   // ----------------------------------------
   // Nibble order: high alarm, low alarm, high warning, low warning.
   for (genvar m = 0; m < NUM_MON; m++) begin : g_mon
      logic [7:0] val;
      assign val = mem_q[10'(MON_VAL_FIRST) + 10'(m)];
      assign mon_nib[m] = {val > mem_q[THR_FLAT + 10'(4 * m)],
                           val < mem_q[THR_FLAT + 10'(4 * m + 1)],
                           val > mem_q[THR_FLAT + 10'(4 * m + 2)],
                           val < mem_q[THR_FLAT + 10'(4 * m + 3)]};
   end

   // ----------------------------------------
   // Latched flags
   // ----------------------------------------
   assign flag_set[0] = {tx_los_s, rx_los_s};
   assign flag_set[1] = {4'h0, tx_fault_s};
   assign flag_set[2] = 8'h00;

   for (genvar k = 0; k < NUM_MON / 2; k++) begin : g_mon_byte
      assign flag_set[FLAG_MON_BYTE0 + k] = {mon_nib[2 * k], mon_nib[2 * k + 1]};
   end

   for (genvar f = 0; f < FLAG_BYTES; f++) begin : g_flag
      logic clr;
      assign clr = link_rd & (link_ptr == FLAG_FIRST + 8'(f));
      // A new event in the clearing cycle survives the clear.
      always_ff @(posedge clock_i) begin
         if (reset_i) begin
            flag_q[f] <= 8'h00;
         end else begin
            flag_q[f] <= (clr ? 8'h00 : flag_q[f]) | flag_set[f];
         end
      end
      assign irq_bits[f] = |(flag_q[f] & ~mem_q[10'(MASK_FIRST) + 10'(f)]);
   end

   // ----------------------------------------
   // Interrupt output
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         int_active_q <= 1'b0;
      end else begin
         int_active_q <= |irq_bits;
      end
   end

   assign interrupt_out_n_o = ~int_active_q;

   // ----------------------------------------
   // Lane controls
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         tx_disable_o <= 4'h0;
         tx_squelch_o <= 4'h0;
         rx_squelch_o <= 4'h0;
      end else begin
         tx_disable_o <= mem_q[CHAN_DIS_OFS][3:0] | tx_fault_s;
         tx_squelch_o <= tx_los_s & ~mem_q[SQ_DIS_OFS][3:0];
         rx_squelch_o <= (rx_los_s & ~mem_q[SQ_DIS_OFS][7:4]) |
                         mem_q[CHAN_DIS_OFS][7:4];
      end
   end

   // ----------------------------------------
   // AHB-Lite slave
   // ----------------------------------------
   assign ahb_idx = haddr_i[12:2];

   // Firmware reads do not clear flags; only the host link does.
   always_comb begin
      ahb_rd_word = 32'h0000_0000;
      if (ahb_idx == STATUS_IDX) begin
         ahb_rd_word = {19'h00000, int_active_q, pin_sync_q};
      end else if (ahb_idx < 11'(MEM_BYTES)) begin
         if ((ahb_idx >= 11'(FLAG_FIRST)) && (ahb_idx < 11'(FLAG_FIRST) + 11'(FLAG_BYTES))) begin
            ahb_rd_word = {24'h000000, flag_q[4'(ahb_idx - 11'(FLAG_FIRST))]};
         end else begin
            ahb_rd_word = {24'h000000, mem_q[ahb_idx[9:0]]};
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ap_valid_q <= 1'b0;
         ap_write_q <= 1'b0;
         ap_idx_q <= 11'h000;
         hrdata_q <= 32'h0000_0000;
      end else if (hready_i) begin
         ap_valid_q <= hsel_i & htrans_i[1];
         ap_write_q <= hwrite_i;
         ap_idx_q <= ahb_idx;
         if (hsel_i && htrans_i[1] && !hwrite_i) begin
            hrdata_q <= ahb_rd_word;
         end
      end
   end

   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = hrdata_q;
endmodule

// ### tmm_properties.sv
// Port checker for the management monitor core.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module tmm_properties (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic interrupt_out_n_o,
   input wire logic [tmm_pkg::LANES-1:0] tx_los_i,
   input wire logic [tmm_pkg::LANES-1:0] tx_fault_i,
   input wire logic [tmm_pkg::LANES-1:0] tx_disable_o,
   input wire logic [tmm_pkg::LANES-1:0] tx_squelch_o,
   input wire logic [tmm_pkg::LANES-1:0] rx_squelch_o,
   input wire logic hsel_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic [31:0] hrdata_o
);
   import tmm_pkg::*;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);
   // ---------------
   // Assertions
   // ---------------
   AST_RESET_STATE: assert property ($fell(reset_i) |-> interrupt_out_n_o && !sda_oe_o
      && !(|{tx_disable_o, tx_squelch_o, rx_squelch_o}) && hrdata_o == 32'h0)
      else $error("outputs not idle after reset");
   AST_BUS_OKAY: assert property (hreadyout_o && !hresp_o)
      else $error("bus stalled or errored");
   AST_RDATA_HOLD: assert property (!(hsel_i && hready_i && htrans_i[1] && !hwrite_i)
      |=> $stable(hrdata_o)) else $error("read data moved without a read");
   AST_SDA_OPEN: assert property (!sda_o)
      else $error("data pin driven high");
   AST_SDA_ON_FALL: assert property ($changed(sda_oe_o) |-> !$past(scl_i))
      else $error("data changed while link clock high");
   AST_SDA_IDLE: assert property (scl_i [*8] |-> !sda_oe_o)
      else $error("data held between frames");
   AST_FAULT_DIS: assert property ($stable(tx_fault_i) [*6] |->
      (tx_disable_o & tx_fault_i) == tx_fault_i) else $error("faulty lane not disabled");
   AST_TX_SQ_CAUSE: assert property ($stable(tx_los_i) [*6] |->
      (tx_squelch_o & ~tx_los_i) == 4'h0) else $error("squelch without signal loss");
   COV_IRQ: cover property ($fell(interrupt_out_n_o));
   COV_ACK: cover property ($rose(sda_oe_o));
   COV_DIS: cover property ($rose(|tx_disable_o));
endmodule

bind tmm_top tmm_properties u_props (.clock_i(clock_i), .reset_i(reset_i), .scl_i(scl_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .interrupt_out_n_o(interrupt_out_n_o),
   .tx_los_i(tx_los_i), .tx_fault_i(tx_fault_i), .tx_disable_o(tx_disable_o),
   .tx_squelch_o(tx_squelch_o), .rx_squelch_o(rx_squelch_o), .hsel_i(hsel_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o));

// ### tmm_host_model.sv
// Host controller model for the two-wire management link.
// Assumes a pull-up on the data line; the bench resolves the wire.
`timescale 1ns/1ps
module tmm_host_model (
   input wire logic clock_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_pull_o
);
   // Extra low-phase clocks; zero gives the nominal 160 ns link period
   int lo_wait = 0;
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   // ---------------
   // Line drivers
   // ---------------
   // Clock rests high between frames; data moves only while it is low, except for the start and stop conditions.
   // The low phase outlasts the device's launch delay of three clocks.
   task automatic drive(input logic c, input logic p, input int w);
      scl_o <= c;
      sda_pull_o <= p;
      repeat (w) @(posedge clock_i);
   endtask
   task automatic start();
      drive(1'b0, sda_pull_o, 1);
      drive(1'b0, 1'b0, 4);
      drive(1'b1, 1'b0, 4);
      drive(1'b1, 1'b1, 4);
      drive(1'b0, 1'b1, 2);
   endtask
   task automatic stop();
      drive(1'b0, sda_pull_o, 1);
      drive(1'b0, 1'b1, 3);
      drive(1'b1, 1'b1, 4);
      drive(1'b1, 1'b0, 4);
   endtask
   task automatic bit_out(input logic b);
      drive(1'b0, sda_pull_o, 1);
      drive(1'b0, !b, 3 + lo_wait);
      drive(1'b1, !b, 4);
   endtask
   task automatic bit_in(output logic b);
      drive(1'b0, sda_pull_o, 1);
      drive(1'b0, 1'b0, 3 + lo_wait);
      drive(1'b1, 1'b0, 3);
      b = sda_i;
      drive(1'b1, 1'b0, 1);
   endtask
   task automatic put_byte(input logic [7:0] v, output logic ack_n);
      for (int i = 7; i >= 0; i--) begin
         bit_out(v[i]);
      end
      bit_in(ack_n);
   endtask
   task automatic get_byte(output logic [7:0] v, input logic last);
      for (int i = 7; i >= 0; i--) begin
         bit_in(v[i]);
      end
      bit_out(last);
   endtask
endmodule

// ### tmm_tb.sv
// Self-checking bench for the transceiver management monitor core.
// Assumes the host model and the port checker are compiled before it.
`timescale 1ns/1ps
module tb_top;
   import tmm_pkg::*;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic [LANES-1:0] tx_los_i = 4'h0;
   logic [LANES-1:0] tx_fault_i = 4'h0;
   logic [LANES-1:0] rx_los_i = 4'h0;
   logic [LANES-1:0] tx_dis, tx_sq, rx_sq;
   logic hsel_i = 1'b0;
   logic hwrite_i = 1'b0;
   logic [1:0] htrans_i = 2'h0;
   logic [31:0] haddr_i = 32'h0;
   logic [31:0] hwdata_i = 32'h0;
   logic [31:0] hrdata, r, mon_e, res_d;
   logic hready, hresp, scl, sda_pull, sda_oe, sda_out, irq_n, ack;
   logic res_v = 1'b0;
   logic [7:0] g0, g1, d0, d1;
   wire sda_w = !(sda_pull || sda_oe);
   string mon_n;
   logic [31:0] exp_q[$];
   string nm_q[$];
   int miscompares = 0;
   int num_checks = 0;
   int seed = 67;

   always #10 clock_i = ~clock_i;

   tmm_top u_dut (.clock_i(clock_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_out), .sda_oe_o(sda_oe), .interrupt_out_n_o(irq_n), .tx_los_i(tx_los_i),
      .tx_fault_i(tx_fault_i), .rx_los_i(rx_los_i), .tx_disable_o(tx_dis),
      .tx_squelch_o(tx_sq), .rx_squelch_o(rx_sq), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
      .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata));
   tmm_host_model u_host (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl),
      .sda_pull_o(sda_pull));

   // ---------------
   // Checking
   // ---------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      exp_q.push_back(e);
      nm_q.push_back(nm);
      res_d <= g;
      res_v <= 1'b1;
      @(posedge clock_i);
      res_v <= 1'b0;
      @(posedge clock_i);
   endtask
   always @(posedge clock_i) begin
      if (res_v === 1'b1) begin
         mon_n = nm_q.pop_front();
         mon_e = exp_q.pop_front();
         num_checks++;
         if (res_d !== mon_e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", mon_n, mon_e, res_d);
         end
      end
   end
   // ---------------
   // Bus and link tasks
   // ---------------
   task automatic wt(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic ready_edge();
      int n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         miscompares++;
         conclude();
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
         output logic [31:0] v);
      hsel_i <= 1'b1;
      haddr_i <= a;
      htrans_i <= 2'h2;
      hwrite_i <= w;
      ready_edge();
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      ready_edge();
      v = hrdata;
   endtask
   task automatic aw(input logic [31:0] a, input logic [31:0] d);
      ahb(1'b1, a, d, r);
   endtask
   task automatic ar_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0, r);
      chk(nm, e, r);
   endtask
   task automatic lwr(input logic [7:0] off, input logic [7:0] d);
      u_host.start();
      u_host.put_byte(8'hA0, ack);
      u_host.put_byte(off, ack);
      u_host.put_byte(d, ack);
      u_host.stop();
   endtask
   // Random read of two consecutive bytes, host refuses the second
   task automatic lrd(input logic [7:0] off, output logic [7:0] b0, output logic [7:0] b1);
      u_host.start();
      u_host.put_byte(8'hA0, ack);
      u_host.put_byte(off, ack);
      u_host.start();
      u_host.put_byte(8'hA1, ack);
      u_host.get_byte(b0, 1'b0);
      u_host.get_byte(b1, 1'b1);
      u_host.stop();
   endtask
   // ---------------
   // Scenarios
   // ---------------
   initial begin
      wt(12);
      reset_i <= 1'b0;
      wt(1);
      ar_chk("status", 32'hA00, 32'h0);
      ar_chk("hi_thr", 32'h800, 32'hFF);
      aw(32'hA04, 32'h5A);
      ar_chk("unmapped", 32'hA04, 32'h0);
      chk("irq_idle", 32'h1, 32'(irq_n));
      $display("test reset done");
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      lwr(8'h7F, 8'h02);
      u_host.lo_wait = 5;
      u_host.start();
      u_host.put_byte(8'hA0, ack);
      chk("ack", 32'h0, 32'(ack));
      u_host.put_byte(8'h80, ack);
      u_host.put_byte(d0, ack);
      u_host.put_byte(d1, ack);
      u_host.stop();
      u_host.lo_wait = 0;
      lrd(8'h80, g0, g1);
      chk("seq0", 32'(d0), 32'(g0));
      chk("seq1", 32'(d1), 32'(g1));
      ar_chk("page2", 32'h604, 32'(d1));
      lwr(8'h10, d0);
      ar_chk("ro_lower", 32'h40, 32'h0);
      u_host.start();
      u_host.put_byte(8'hA2, ack);
      u_host.stop();
      chk("nack", 32'h1, 32'(ack));
      $display("test link done");
      tx_los_i <= 4'h2;
      rx_los_i <= 4'h4;
      wt(8);
      chk("tx_sq", 32'h2, 32'(tx_sq));
      chk("rx_sq", 32'h4, 32'(rx_sq));
      tx_los_i <= 4'h0;
      rx_los_i <= 4'h0;
      wt(8);
      chk("irq_set", 32'h0, 32'(irq_n));
      lrd(8'h03, g0, g1);
      chk("los_flag", 32'h24, 32'(g0));
      lrd(8'h03, g0, g1);
      chk("los_clr", 32'h0, 32'(g0));
      chk("irq_clr", 32'h1, 32'(irq_n));
      aw(32'h190, 32'hFF);
      rx_los_i <= 4'h1;
      wt(8);
      rx_los_i <= 4'h0;
      wt(8);
      chk("irq_mask", 32'h1, 32'(irq_n));
      lrd(8'h03, g0, g1);
      chk("mask_flag", 32'h1, 32'(g0));
      aw(32'h190, 32'h0);
      $display("test flags done");
      aw(32'h158, 32'h11);
      aw(32'h15C, 32'h02);
      tx_fault_i <= 4'h8;
      tx_los_i <= 4'h2;
      wt(8);
      chk("tx_dis", 32'h9, 32'(tx_dis));
      chk("rx_cmd", 32'h1, 32'(rx_sq));
      chk("sq_off", 32'h0, 32'(tx_sq));
      ar_chk("status", 32'hA00, 32'h1280);
      tx_fault_i <= 4'h0;
      tx_los_i <= 4'h0;
      aw(32'h158, 32'h0);
      aw(32'h15C, 32'h0);
      wt(8);
      chk("tx_en", 32'h0, 32'(tx_dis));
      lrd(8'h03, g0, g1);
      chk("txlos_kept", 32'h20, 32'(g0));
      chk("fault_flag", 32'h8, 32'(g1));
      $display("test lanes done");
      aw(32'h800, 32'h10);
      aw(32'h58, 32'h20);
      wt(4);
      aw(32'h58, 32'h0);
      aw(32'h800, 32'hFF);
      chk("irq_mon", 32'h0, 32'(irq_n));
      lrd(8'h06, g0, g1);
      chk("mon_flag", 32'h80, 32'(g0));
      $display("test monitor done");
      conclude();
   end
endmodule
